// >>> core/csc_current_sense_config.v
/*
 Paged current sense configuration word with blanking window and
 consecutive-event fault qualification for each output page.
 Assumes the bus interface decodes transactions into one-cycle command
 strobes, the page input is the currently selected page, and the
 switching-cycle boundary and event inputs are synchronous to mclk_i.
*/
`include "csc_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module csc_current_sense_config #(
    parameter PAGES = 2,
    parameter PAGE_W = 1
) (
    // clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // command port
    input wire cmd_valid_i,
    input wire cmd_write_i,
    input wire [7:0] cmd_code_i,
    input wire [PAGE_W-1:0] page_i,
    input wire [15:0] cmd_wdata_i,
    output reg cmd_ack_o,
    output reg cmd_nack_o,
    output reg [15:0] cmd_rdata_o,
    // switching cycle and sense events, one bit per page
    input wire [PAGES-1:0] sw_cycle_i,
    input wire [PAGES-1:0] sense_event_i,
    // decoded settings and protection, one field per page
    output wire [PAGES-1:0] blank_active_o,
    output wire [PAGES*2-1:0] sense_method_o,
    output wire [PAGES*2-1:0] sense_range_o,
    output wire [PAGES-1:0] fault_o
);

    // shared constants, sized once here so no assignment drops bits
    localparam integer BLANK_STEP_CYC = `CSC_BLANK_STEP_CYC;
    localparam [7:0] CMD_CONFIG = `CSC_CMD_CONFIG;
    localparam [15:0] RESET_VALUE = `CSC_RESET_VALUE;
    localparam [15:0] WRITE_MASK = `CSC_WRITE_MASK;

    // needed run of event cycles: twice the code plus one
    function [3:0] fault_threshold;
        input [2:0] code;
        begin
            fault_threshold = {code, 1'b1};
        end
    endfunction

    // blanking length in clock cycles; largest code still fits 8 bits
    function [7:0] blank_load;
        input [4:0] code;
        reg [31:0] full;
        begin
            full = code * BLANK_STEP_CYC;
            blank_load = full[7:0];
        end
    endfunction

    // one stored word per output page
    reg [15:0] cfg [0:PAGES-1];

    // command decode
    wire hit;
    wire page_ok;
    wire accept;
    reg next_ack;
    reg next_nack;

    assign hit = (cmd_code_i == CMD_CONFIG);
    assign page_ok = (page_i < PAGES);
    assign accept = cmd_valid_i && hit && page_ok;

    // refusal leaves every word untouched
    always @* begin
        next_ack = accept;
        next_nack = cmd_valid_i && !accept;
    end

    // command handling: answer one cycle after the strobe
    integer p;
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (p = 0; p < PAGES; p = p + 1) begin
                cfg[p] <= RESET_VALUE;
            end
            cmd_ack_o <= 1'b0;
            cmd_nack_o <= 1'b0;
            cmd_rdata_o <= 16'h0000;
        end else begin
            cmd_ack_o <= next_ack;
            cmd_nack_o <= next_nack;
            if (accept && cmd_write_i) begin
                // unused bits 7:4 are not stored and read back as zero
                cfg[page_i] <= cmd_wdata_i & WRITE_MASK;
            end
            if (accept && !cmd_write_i) begin
                // read data held until the next accepted read
                cmd_rdata_o <= cfg[page_i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < PAGES; g = g + 1) begin : page
            wire [15:0] word;
            wire [4:0] blank_code;
            wire [2:0] count_code;
            wire [3:0] threshold;
            wire blanking;
            wire evt_now;
            wire evt_cycle;
            reg [7:0] blank_cnt;
            reg evt_seen;
            reg [3:0] run_cnt;
            reg [7:0] next_blank_cnt;
            reg next_evt_seen;
            reg [3:0] next_run_cnt;

            assign word = cfg[g];
            assign blank_code = word[`CSC_BLANK_HI:`CSC_BLANK_LO];
            assign count_code = word[`CSC_COUNT_HI:`CSC_COUNT_LO];
            assign threshold = fault_threshold(count_code);
            assign blanking = (blank_cnt != 8'h00);

            // events inside the blanking window are switching noise
            assign evt_now = sense_event_i[g] && !blanking;

            // boundary cycle's own event belongs to the cycle it closes
            assign evt_cycle = evt_seen || evt_now;

            // blanking window: reload at every boundary, else run down
            always @* begin
                next_blank_cnt = blank_cnt;
                if (sw_cycle_i[g]) begin
                    // whole 32 ns steps from cycle start
                    next_blank_cnt = blank_load(blank_code);
                end else if (blanking) begin
                    next_blank_cnt = blank_cnt - 8'h01;
                end
            end

            // event latch: one event at most per switching cycle
            always @* begin
                next_evt_seen = evt_seen;
                if (sw_cycle_i[g]) begin
                    next_evt_seen = 1'b0;
                end else if (evt_now) begin
                    next_evt_seen = 1'b1;
                end
            end

            // run counter: updated at each boundary, saturates at threshold
            always @* begin
                next_run_cnt = run_cnt;
                if (sw_cycle_i[g]) begin
                    if (!evt_cycle) begin
                        next_run_cnt = 4'h0;
                    end else if (run_cnt < threshold) begin
                        next_run_cnt = run_cnt + 4'h1;
                    end
                end
            end

            // writing the word leaves the counters running on purpose
            always @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    blank_cnt <= 8'h00;
                    evt_seen <= 1'b0;
                    run_cnt <= 4'h0;
                end else begin
                    blank_cnt <= next_blank_cnt;
                    evt_seen <= next_evt_seen;
                    run_cnt <= next_run_cnt;
                end
            end

            // >= keeps the fault honest if the count code is lowered mid-run
            assign fault_o[g] = (run_cnt >= threshold);
            assign blank_active_o[g] = blanking;
            // code 00 is passed through unchanged; the front end treats it as unused
            assign sense_method_o[g*2 +: 2] = cfg[g][`CSC_METHOD_HI:`CSC_METHOD_LO];
            // code 11 likewise passed through as written
            assign sense_range_o[g*2 +: 2] = cfg[g][`CSC_RANGE_HI:`CSC_RANGE_LO];
        end
    endgenerate

endmodule // csc_current_sense_config

`default_nettype wire

// >>> pkg/csc_consts.vh
/*
 Constants for the current sense configuration block: command code,
 field positions, reset value and blanking timing.
 Assumes a 250 MHz system clock.
*/
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

`define CSC_CMD_CONFIG 8'hD0
`define CSC_RESET_VALUE 16'h620E
`define CSC_WRITE_MASK 16'hFF0F
`define CSC_BLANK_HI 15
`define CSC_BLANK_LO 11
`define CSC_COUNT_HI 10
`define CSC_COUNT_LO 8
`define CSC_METHOD_HI 3
`define CSC_METHOD_LO 2
`define CSC_RANGE_HI 1
`define CSC_RANGE_LO 0
`define CSC_METHOD_DOWN_SLOPE 2'h1
`define CSC_METHOD_UP_SLOPE 2'h2
`define CSC_METHOD_STAGE_MON 2'h3
`define CSC_RANGE_LOW 2'h0
`define CSC_RANGE_MEDIUM 2'h1
`define CSC_RANGE_HIGH 2'h2
`define CSC_BLANK_STEP_NS 32
`define CSC_CLK_PERIOD_NS 4
`define CSC_BLANK_STEP_CYC ((`CSC_BLANK_STEP_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)

`endif

// >>> testbench/csc_chk.sv
/* checker for the paged sense word: answers, page 0 fields, fault and blank
   timing; bound to csc_current_sense_config with two pages */
`timescale 1ns/10ps
`default_nettype none
module csc_chk(input wire logic mclk_i, sys_rst_i, cmd_valid_i, cmd_write_i, cmd_ack_o,
    input wire logic cmd_nack_o, page_i, input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i, cmd_rdata_o, input wire logic [1:0] sw_cycle_i,
    input wire logic [1:0] blank_active_o, fault_o, input wire logic [3:0] sense_method_o,
    input wire logic [3:0] sense_range_o);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic hit = cmd_valid_i && cmd_code_i == 8'hD0;
    ack_mapped_a: assert property (hit |=> cmd_ack_o && !cmd_nack_o) else $error("no ack");
    nack_unmapped_a: assert property (cmd_valid_i && !hit |=> cmd_nack_o && !cmd_ack_o)
        else $error("no nack");
    idle_quiet_a: assert property (!cmd_valid_i |=> !cmd_ack_o && !cmd_nack_o)
        else $error("stray");
    write_fields_a: assert property (hit && cmd_write_i && !page_i |=>
        {sense_method_o[1:0], sense_range_o[1:0]} == $past(cmd_wdata_i[3:0])) else $error("field");
    page_apart_a: assert property (cmd_valid_i && page_i |=> $stable(sense_method_o[1:0])
        && $stable(sense_range_o[1:0])) else $error("page leak");
    unused_zero_a: assert property (cmd_ack_o |-> cmd_rdata_o[7:4] == 4'h0) else $error("b7:4");
    fault_boundary_a: assert property ($changed(fault_o[0]) && !$past(cmd_valid_i)
        |-> $past(sw_cycle_i[0])) else $error("fault moved off boundary");
    blank_start_a: assert property ($rose(blank_active_o[0]) |-> $past(sw_cycle_i[0]))
        else $error("blank start");
    cover property (hit && cmd_write_i);
    cover property (cmd_nack_o);
    cover property ($rose(fault_o[0]));
    cover property ($rose(blank_active_o[0]));
endmodule // csc_chk
`default_nettype wire

// >>> testbench/csc_current_sense_config_tb.sv
/* bench for the sense word: reset, random paged access, refusal, fault count
   and blanking; assumes csc_host on the command port */
`timescale 1ns/10ps
`default_nettype none
module csc_current_sense_config_tb;
    logic mclk_i = 0, sys_rst_i = 1, pg, ack, nack, cv, cw;
    logic [7:0] code; logic [15:0] wd, rd, d; logic [17:0] r; logic [15:0] m [2];
    logic [1:0] sw = 0, ev = 0, blank, fault; logic [3:0] meth, rng;
    int n_errors = 0, compares = 0, n;
    initial forever #2 mclk_i = ~mclk_i;
    csc_current_sense_config dut(.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cv),
        .cmd_write_i(cw), .cmd_code_i(code), .page_i(pg), .cmd_wdata_i(wd), .cmd_ack_o(ack),
        .cmd_nack_o(nack), .cmd_rdata_o(rd), .sw_cycle_i(sw), .sense_event_i(ev),
        .blank_active_o(blank), .sense_method_o(meth), .sense_range_o(rng), .fault_o(fault));
    csc_host host(.clk(mclk_i), .ack_i(ack), .nack_i(nack), .rdata_i(rd), .valid_o(cv),
        .write_o(cw), .page_o(pg), .code_o(code), .wdata_o(wd));
    task chk(input logic [17:0] s, e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // fault expected once the run reaches twice the code plus one
    function automatic logic exp_fault(int k, int c);
        return k >= 2 * c + 1;
    endfunction
    // blanking cycles: 32 ns steps on a 4 ns clock
    function automatic int exp_blank(int b);
        return b * 32 / 4;
    endfunction
    task bnd(input logic e);
        @(posedge mclk_i) ev <= {2{e}};
        @(posedge mclk_i) begin ev <= 0; sw <= 2'h3; end
        @(posedge mclk_i) sw <= 0;
        #1;
    endtask
    initial begin
        d = $urandom(32'hac7b4618);
        m = '{16'h620E, 16'h620E};
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 0;
        chk({10'h0, meth, rng}, 18'hFA);
        repeat (8) begin
            d = $urandom;
            n = $urandom % 2;
            host.xfer(1, 8'hD0, n[0], d, r);
            m[n] = d & 16'hFF0F;
            for (int q = 0; q < 2; q++) begin
                host.xfer(0, 8'hD0, q[0], 0, r);
                chk(r, {2'b10, m[q]});
            end
        end
        host.xfer(0, 8'hD1, 0, 0, r);
        chk({r[17:16], 16'h0}, 18'h10000);
        for (int c = 0; c < 8; c++) begin
            host.xfer(1, 8'hD0, 0, {5'h0, c[2:0], 8'h0F}, r);
            bnd(0);
            for (int k = 1; k <= 2 * c + 2; k++) begin
                bnd(1);
                chk({17'h0, fault[0]}, {17'h0, exp_fault(k, c)});
            end
            bnd(0);
            chk({17'h0, fault[0]}, 18'h0);
        end
        for (int b = 1; b < 27; b += 25) begin
            host.xfer(1, 8'hD0, 0, {b[4:0], 11'h00F}, r);
            bnd(0);
            n = 0;
            repeat (300) begin n += blank[0]; @(posedge mclk_i); #1; end
            chk(n[17:0], exp_blank(b));
        end
        // page 1 unblanked, page 0 blanked 32 cycles: event in blanking is refused
        host.xfer(1, 8'hD0, 1, 16'h000F, r);
        host.xfer(1, 8'hD0, 0, {5'h04, 11'h00F}, r);
        chk({10'h0, meth, rng}, 18'hFF);
        bnd(0);
        bnd(1);
        chk({16'h0, fault}, 18'h2);
        repeat (40) @(posedge mclk_i);
        bnd(1);
        chk({16'h0, fault}, 18'h3);
        close_out;
    end
    // run needs some 1000 cycles; limit leaves wide margin
    initial begin #100000; n_errors++; close_out; end
endmodule // csc_current_sense_config_tb
bind csc_current_sense_config csc_chk chk_i(.*);
`default_nettype wire

// >>> testbench/csc_host.sv
/* host side of the command port: one-cycle strobe, answer read a cycle later;
   assumes the clock of the block */
`timescale 1ns/10ps
`default_nettype none
module csc_host(input wire logic clk, ack_i, nack_i, input wire logic [15:0] rdata_i,
    output logic valid_o = 0, write_o = 0, page_o = 0, output logic [7:0] code_o = 0,
    output logic [15:0] wdata_o = 0);
    task xfer(input logic w, input logic [7:0] c, input logic p, input logic [15:0] d,
        output logic [17:0] r);
        @(posedge clk);
        valid_o <= 1; write_o <= w; code_o <= c; page_o <= p; wdata_o <= d;
        @(posedge clk);
        // released code, page and data lines flip so stale values never look valid
        valid_o <= 0; code_o <= ~c; page_o <= ~p; wdata_o <= ~d;
        #1 r = {ack_i, nack_i, rdata_i};
    endtask
endmodule // csc_host
`default_nettype wire
